//--- rfe_pkg.sv
// Constants shared by the radio front end datapath top.
// Assumes a single 200 MHz clock shared with the SoC IQ network.
package rfe_pkg;
  localparam int CLK_MHZ = 200;
  localparam int ADDR_W = 8;
  localparam int SMP_W = 32;
  localparam int NSLICE = 4;
  localparam int NLINK = 2;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SLICE = 8'h04;
  localparam logic [7:0] OFS_NCO = 8'h08;
  localparam logic [7:0] OFS_IRQ_PEND = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // Control, slice and interrupt enable register fields
  localparam int CTRL_STREAMS_LSB = 0;
  localparam int CTRL_BYPASS = 3;
  localparam int CTRL_FB_TO_RX = 4;
  localparam int CTRL_LANE2_ALT = 5;
  localparam int CTRL_LANE3_ALT = 6;
  localparam int CTRL_SYNC_LSB = 7;
  localparam int CTRL_SYSREF_REQ = 9;
  localparam int CTRL_DECIM_LSB = 10;
  localparam int SLICE_CARR_LSB = 4;
  localparam int IRQ_EN1_LSB = 8;
  // Interrupt source bits
  localparam int IRQ_SYNC0 = 0;
  localparam int IRQ_SYNC1 = 1;
  localparam int IRQ_SYSREF = 2;
  localparam int IRQ_RATE = 3;
  localparam int IRQ_CAPT = 4;
  localparam int NIRQ = 5;
  // Reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0001;
  localparam logic [31:0] RST_SLICE = 32'h0000_0010;
  localparam logic [31:0] RST_NCO = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_EN = 32'h0000_0000;
  // Stream rate dividers: 1, 2, 4 streams
  localparam logic [3:0] DIV_1STREAM = 4'h2;
  localparam logic [3:0] DIV_2STREAM = 4'h4;
  localparam logic [3:0] DIV_4STREAM = 4'h8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

//--- rfe_top.sv
// Radio front end datapath top: IQ bus, control port, lanes, sync and strobes.
// Assumes one clock shared with the SoC IQ network; only sync and SYSREF pins are asynchronous.
// Notes on behaviour
// - All interrupt sources merge onto two strobes
// - 128-bit IQ bus, separate transmit and receive
// - 128-bit control port carries capture and coefficients
// - 32-bit slave bus reaches all configuration
// - Lanes 0,1 direct; lanes 2,3 muxed
// - Two sync in, two sync out, SYSREF
// - One SYSREF request per clock generator
// - Feedback runs at transmit stream rate
// - Feedback goes to capture or to receive slice 3 only
// - Receive rate equals transmit rate; bypass thins it by the decimation setting
// - Bypass forwards raw lanes straight out
// - Receive lanes unpacked into channel containers
// - Each slice chooses up or down conversion
// - Baseband carriers interpolated and frequency shifted
// - Shifted carriers summed into one stream
// - Single carrier uses zero frequency offset
// - FIR, resampler, CIC, mixer in order
// - Stream rate clock/2, /4, /8 by count
// - Everything runs on the shared clock
module rfe_top
#(
  parameter int N_CLKGEN = 1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rfe_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rfe_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [127:0] tx_iq_data,
  input wire logic tx_iq_valid,
  output logic [127:0] rx_iq_data,
  output logic rx_iq_valid,
  input wire logic [127:0] ctl_in_data,
  input wire logic ctl_in_valid,
  output logic [127:0] ctl_out_data,
  output logic ctl_out_valid,
  input wire logic [127:0] rx_lane_data,
  input wire logic [31:0] fb_data,
  input wire logic [63:0] alt_lane_data,
  output logic [127:0] tx_lane_data,
  input wire logic [rfe_pkg::NLINK-1:0] sync_in,
  output logic [rfe_pkg::NLINK-1:0] sync_out,
  input wire logic sysref_in,
  output logic [N_CLKGEN-1:0] sysref_req,
  output logic [1:0] irq_strobe
);
  import rfe_pkg::*;

  initial
  begin
    if (N_CLKGEN < 1) $error("N_CLKGEN must be at least 1");
  end

  typedef logic [SMP_W-1:0] rfe_smp_t;

  // Mean of two IQ samples, per component
  function automatic rfe_smp_t rfe_avg(input rfe_smp_t a, input rfe_smp_t b);
    logic signed [16:0] si;
    logic signed [16:0] sq;
    si = 17'(signed'(a[31:16])) + 17'(signed'(b[31:16]));
    sq = 17'(signed'(a[15:0])) + 17'(signed'(b[15:0]));
    return {si[16:1], sq[16:1]};
  endfunction

  // Rotate by quarter turns: cheap mixer, no multiplier
  function automatic rfe_smp_t rfe_rot(input rfe_smp_t a, input logic [1:0] q);
    logic [15:0] i;
    logic [15:0] qq;
    i = a[31:16];
    qq = a[15:0];
    unique case (q)
      2'h0: return a;
      2'h1: return {16'h0000 - qq, i};
      2'h2: return {16'h0000 - i, 16'h0000 - qq};
      2'h3: return {qq, 16'h0000 - i};
    endcase
  endfunction

  // Component-wise wrapping add
  function automatic rfe_smp_t rfe_add(input rfe_smp_t a, input rfe_smp_t b);
    return {16'(a[31:16] + b[31:16]), 16'(a[15:0] + b[15:0])};
  endfunction

  logic [31:0] ctrl_reg;
  logic [31:0] slice_reg;
  logic [31:0] nco_reg;
  logic [31:0] irq_en_reg;
  logic [NIRQ-1:0] irq_pend_reg;
  logic [NIRQ-1:0] irq_set;

  // Two-flop synchronisers for asynchronous pins
  logic [NLINK-1:0] sync_m_reg;
  logic [NLINK-1:0] sync_s_reg;
  logic [NLINK-1:0] sync_d_reg;
  logic sysref_m_reg;
  logic sysref_s_reg;
  logic sysref_d_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_m_reg <= '0;
      sync_s_reg <= '0;
      sync_d_reg <= '0;
      sysref_m_reg <= 1'b0;
      sysref_s_reg <= 1'b0;
      sysref_d_reg <= 1'b0;
    end
    else
    begin
      sync_m_reg <= sync_in;
      sync_s_reg <= sync_m_reg;
      sync_d_reg <= sync_s_reg;
      sysref_m_reg <= sysref_in;
      sysref_s_reg <= sysref_m_reg;
      sysref_d_reg <= sysref_s_reg;
    end
  end

  // AXI4-Lite write: address and data taken in either order
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic [31:0] wmask;
  assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg[7:2] <= OFS_STATUS[7:2]) ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers, byte lanes honoured
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= RST_CTRL;
      slice_reg <= RST_SLICE;
      nco_reg <= RST_NCO;
      irq_en_reg <= RST_IRQ_EN;
    end
    else if (wr_fire)
    begin
      unique case (aw_addr_reg)
        OFS_CTRL: ctrl_reg <= (ctrl_reg & ~wmask) | (w_data_reg & wmask);
        OFS_SLICE: slice_reg <= (slice_reg & ~wmask) | (w_data_reg & wmask);
        OFS_NCO: nco_reg <= (nco_reg & ~wmask) | (w_data_reg & wmask);
        OFS_IRQ_EN: irq_en_reg <= (irq_en_reg & ~wmask) | (w_data_reg & wmask);
        default: ;
      endcase
    end
  end

  // Pending bits: write one clears, a new event in the same cycle wins
  logic [NIRQ-1:0] irq_clr;
  assign irq_clr = (wr_fire && aw_addr_reg == OFS_IRQ_PEND) ? w_data_reg[NIRQ-1:0] & wmask[NIRQ-1:0] : '0;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_pend_reg <= '0;
    else
      irq_pend_reg <= (irq_pend_reg & ~irq_clr) | irq_set;
  end

  // Strobe on rising edge of any enabled pending source
  logic [NIRQ-1:0] irq_act0_reg;
  logic [NIRQ-1:0] irq_act1_reg;
  logic [NIRQ-1:0] act0;
  logic [NIRQ-1:0] act1;
  assign act0 = irq_pend_reg & irq_en_reg[NIRQ-1:0];
  assign act1 = irq_pend_reg & irq_en_reg[IRQ_EN1_LSB +: NIRQ];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_act0_reg <= '0;
      irq_act1_reg <= '0;
      irq_strobe <= 2'h0;
    end
    else
    begin
      irq_act0_reg <= act0;
      irq_act1_reg <= act1;
      irq_strobe[0] <= |(act0 & ~irq_act0_reg);
      irq_strobe[1] <= |(act1 & ~irq_act1_reg);
    end
  end

  // Stream rate from configured stream count
  logic [3:0] div_val;
  logic rate_ok;
  logic [3:0] div_cnt_reg;
  logic tick_reg;
  always_comb
  begin
    rate_ok = 1'b1;
    unique case (ctrl_reg[CTRL_STREAMS_LSB +: 3])
      3'h1: div_val = DIV_1STREAM;
      3'h2: div_val = DIV_2STREAM;
      3'h4: div_val = DIV_4STREAM;
      default:
      begin
        div_val = DIV_1STREAM;
        rate_ok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rate_ok)
    begin
      div_cnt_reg <= 4'h0;
      tick_reg <= 1'b0;
    end
    else
    begin
      div_cnt_reg <= (div_cnt_reg >= div_val - 4'h1) ? 4'h0 : div_cnt_reg + 4'h1;
      tick_reg <= (div_cnt_reg == div_val - 4'h1);
    end
  end

  // Baseband carriers latched as they arrive, interleaved one per slice
  logic [127:0] bb_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bb_reg <= '0;
    else if (tx_iq_valid)
      bb_reg <= tx_iq_data;
  end

  // Feedback path: equalising average at the transmit tick
  logic [31:0] fb_prev_reg;
  logic [31:0] fb_out_reg;
  logic [127:0] coef_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fb_prev_reg <= '0;
      fb_out_reg <= '0;
      coef_reg <= '0;
    end
    else
    begin
      if (ctl_in_valid)
        coef_reg <= ctl_in_data;
      if (tick_reg)
      begin
        fb_prev_reg <= fb_data;
        fb_out_reg <= rfe_rot(rfe_avg(fb_data, fb_prev_reg), coef_reg[1:0]);
      end
    end
  end

  // Slice chain: FIR, resampler, CIC, mixer
  logic [3:0] slice_rx;
  logic one_carrier;
  logic [SMP_W-1:0] s_in [NSLICE];
  logic [SMP_W-1:0] fir_prev_reg [NSLICE];
  logic [SMP_W-1:0] fir_reg [NSLICE];
  logic [SMP_W-1:0] rs_reg [NSLICE];
  logic [SMP_W-1:0] cic_reg [NSLICE];
  logic [SMP_W-1:0] mix_reg [NSLICE];
  logic [1:0] phase_reg [NSLICE];
  assign slice_rx = slice_reg[3:0];
  assign one_carrier = slice_reg[SLICE_CARR_LSB +: 3] == 3'h1;
  always_comb
  begin
    for (int s = 0; s < NSLICE; s++)
    begin
      if (!slice_rx[s])
        s_in[s] = bb_reg[s*SMP_W +: SMP_W];
      else if (s == NSLICE - 1 && ctrl_reg[CTRL_FB_TO_RX])
        s_in[s] = fb_out_reg;
      else
        s_in[s] = rx_lane_data[s*SMP_W +: SMP_W];
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int s = 0; s < NSLICE; s++)
      begin
        fir_prev_reg[s] <= '0;
        fir_reg[s] <= '0;
        rs_reg[s] <= '0;
        cic_reg[s] <= '0;
        mix_reg[s] <= '0;
        phase_reg[s] <= 2'h0;
      end
    end
    else
    begin
      for (int s = 0; s < NSLICE; s++)
      begin
        fir_prev_reg[s] <= s_in[s];
        fir_reg[s] <= rfe_avg(s_in[s], fir_prev_reg[s]);
        if (tick_reg)
        begin
          rs_reg[s] <= fir_reg[s];
          cic_reg[s] <= rfe_avg(rs_reg[s], cic_reg[s]);
          // Single carrier sits at zero offset
          phase_reg[s] <= one_carrier ? 2'h0 : 2'(phase_reg[s] + nco_reg[2*s +: 2]);
          // Down conversion turns the other way
          mix_reg[s] <= rfe_rot(cic_reg[s], slice_rx[s] ? 2'(2'h0 - phase_reg[s]) : phase_reg[s]);
        end
      end
    end
  end

  // Sum chain over the transmit slices
  logic [SMP_W-1:0] tx_sum;
  always_comb
  begin
    tx_sum = '0;
    for (int s = 0; s < NSLICE; s++)
      if (!slice_rx[s])
        tx_sum = rfe_add(tx_sum, mix_reg[s]);
  end

  // Lanes 0 and 1 always carry the stream; 2 and 3 may be lent out
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rate_ok)
      tx_lane_data <= '0;
    else if (tick_reg)
    begin
      tx_lane_data[63:0] <= {tx_sum, tx_sum};
      tx_lane_data[95:64] <= ctrl_reg[CTRL_LANE2_ALT] ? alt_lane_data[31:0] : tx_sum;
      tx_lane_data[127:96] <= ctrl_reg[CTRL_LANE3_ALT] ? alt_lane_data[63:32] : tx_sum;
    end
  end

  // Receive containers; bypass skips every processing stage
  logic [3:0] dec_cnt_reg;
  logic [3:0] dec_max;
  logic [127:0] rx_proc;
  assign dec_max = 4'((5'h01 << ctrl_reg[CTRL_DECIM_LSB +: 2]) - 5'h01);
  always_comb
  begin
    for (int s = 0; s < NSLICE; s++)
      rx_proc[s*SMP_W +: SMP_W] = slice_rx[s] ? mix_reg[s] : '0;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rate_ok)
    begin
      dec_cnt_reg <= 4'h0;
      rx_iq_data <= '0;
      rx_iq_valid <= 1'b0;
    end
    else
    begin
      rx_iq_valid <= 1'b0;
      if (tick_reg)
      begin
        // Receive shares the transmit tick
        dec_cnt_reg <= (dec_cnt_reg >= dec_max) ? 4'h0 : dec_cnt_reg + 4'h1;
        if (!ctrl_reg[CTRL_BYPASS])
        begin
          rx_iq_data <= rx_proc;
          rx_iq_valid <= 1'b1;
        end
        else if (dec_cnt_reg == 4'h0)
        begin
          rx_iq_data <= rx_lane_data;
          rx_iq_valid <= 1'b1;
        end
      end
    end
  end

  // Capture: four feedback samples packed into one control word
  logic [1:0] cap_cnt_reg;
  logic cap_tick_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cap_cnt_reg <= 2'h0;
      cap_tick_reg <= 1'b0;
      ctl_out_data <= '0;
      ctl_out_valid <= 1'b0;
    end
    else
    begin
      cap_tick_reg <= tick_reg && rate_ok && !ctrl_reg[CTRL_FB_TO_RX];
      ctl_out_valid <= 1'b0;
      if (cap_tick_reg)
      begin
        ctl_out_data <= {fb_out_reg, ctl_out_data[127:32]};
        cap_cnt_reg <= 2'(cap_cnt_reg + 2'h1);
        ctl_out_valid <= cap_cnt_reg == 2'h3;
      end
    end
  end

  // Sync outputs report own readiness; SYSREF requests go to every generator
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_out <= '0;
      sysref_req <= '0;
    end
    else
    begin
      sync_out <= ctrl_reg[CTRL_SYNC_LSB +: NLINK];
      sysref_req <= {N_CLKGEN{ctrl_reg[CTRL_SYSREF_REQ]}};
    end
  end

  // Event sources: sync falls, SYSREF rises, bad rate, capture word
  always_comb
  begin
    irq_set = '0;
    irq_set[IRQ_SYNC0] = sync_d_reg[0] && !sync_s_reg[0];
    irq_set[IRQ_SYNC1] = sync_d_reg[1] && !sync_s_reg[1];
    irq_set[IRQ_SYSREF] = sysref_s_reg && !sysref_d_reg;
    irq_set[IRQ_RATE] = !rate_ok;
    irq_set[IRQ_CAPT] = ctl_out_valid;
  end

  // Read channel: one data beat per address
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      OFS_CTRL: rd_mux = ctrl_reg;
      OFS_SLICE: rd_mux = slice_reg;
      OFS_NCO: rd_mux = nco_reg;
      OFS_IRQ_PEND: rd_mux = {{(32-NIRQ){1'b0}}, irq_pend_reg};
      OFS_IRQ_EN: rd_mux = irq_en_reg;
      OFS_STATUS: rd_mux = {26'h0, rate_ok, sysref_s_reg, sync_s_reg, cap_cnt_reg};
      default:
      begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // rfe_top

//--- rfe_top_chk.sv
// Checker for the radio front end top: bus handshakes, tick spacing, reset.
// Sees only the top ports; bound to every rfe_top instance.
module rfe_top_chk
  import rfe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_iq_valid,
  input wire logic ctl_out_valid,
  input wire logic [1:0] irq_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Slave bus handshakes and answers
  chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("no write response");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_decerr_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_DECERR |-> s_axi_rdata == 32'h0)
    else $error("unmapped read data not zero");
  // Fastest stream tick is every second clock
  chk_rx_pulse: assert property (rx_iq_valid |=> !rx_iq_valid)
    else $error("receive ticks too close");
  // Capture word needs four ticks of at least two clocks each
  chk_capt_spacing: assert property (ctl_out_valid |=> !ctl_out_valid [*7])
    else $error("capture words too close");
  chk_reset_quiet: assert property ($rose(aresetn) |-> !rx_iq_valid && !ctl_out_valid && irq_strobe == 2'h0)
    else $error("outputs active after reset");
endmodule // rfe_top_chk

bind rfe_top rfe_top_chk rfe_top_chk_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .rx_iq_valid, .ctl_out_valid, .irq_strobe);

//--- rfe_conv_model.sv
// Model of the converter side: sync status, SYSREF, lane and feedback data.
// Driven from the bench by drop and sref, same clock as the top.
module rfe_conv_model
#(
  parameter logic [127:0] LANE = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210,
  parameter logic [31:0] FB = 32'h1357_9BDF
)
(
  input wire logic aclk,
  input wire logic [1:0] drop,
  input wire logic sref,
  output logic [1:0] sync_in,
  output logic sysref_in,
  output logic [127:0] rx_lane_data,
  output logic [31:0] fb_data,
  output logic [63:0] alt_lane_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Known levels from time zero
  initial
  begin
    sync_in = 2'h3;
    sysref_in = 1'b0;
    rx_lane_data = LANE;
    fb_data = FB;
    alt_lane_data = 64'h5A5A_5A5A_5A5A_5A5A;
  end
  // Receiver status low means lost link; unused alt lanes toggle so stale data shows
  always @(posedge aclk)
  begin
    sync_in <= ~drop;
    sysref_in <= sref;
    alt_lane_data <= ~alt_lane_data;
  end
endmodule // rfe_conv_model

//--- rfe_top_bench.sv
// Self-checking bench for rfe_top: registers, stream rates, strobes, pins.
// Assumes rfe_pkg, the converter model and the bound checker are compiled first.
`define CHK(n,e,a) begin check_count++; if ((a)!==(e)) begin err_count++; $display("wrong value %s exp %0h seen %0h",n,e,a); end end
module rfe_top_bench
  import rfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] LANE = 128'hA5A5_0F0F_1234_5678_9ABC_DEF0_C3C3_3C3C;
  localparam logic [31:0] FB = 32'h2468_ACE0;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tx_iq_valid, rx_iq_valid;
  logic ctl_in_valid, ctl_out_valid, sysref_in, sref;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, fb_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, sync_in, sync_out, irq_strobe, drop, sysref_req;
  logic [127:0] tx_iq_data, rx_iq_data, ctl_in_data, ctl_out_data, rx_lane_data, tx_lane_data;
  logic [63:0] alt_lane_data;
  int err_count = 0;
  int check_count = 0;

  rfe_top #(.N_CLKGEN(2)) rfe_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_iq_data, .tx_iq_valid, .rx_iq_data, .rx_iq_valid, .ctl_in_data, .ctl_in_valid, .ctl_out_data,
    .ctl_out_valid, .rx_lane_data, .fb_data, .alt_lane_data, .tx_lane_data, .sync_in, .sync_out, .sysref_in,
    .sysref_req, .irq_strobe);
  rfe_conv_model #(.LANE(LANE), .FB(FB)) rfe_conv_model_inst (.aclk, .drop, .sref, .sync_in, .sysref_in,
    .rx_lane_data, .fb_data, .alt_lane_data);

  // 200 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // A bounded wait ran out
  task automatic lost;
    `CHK("handshake wait", 1'b1, 1'b0)
    tally_and_finish();
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit got;
    got = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (50)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        got = 1;
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
        break;
      end
    end
    if (!got) lost();
  endtask

  // Bus read: data and response taken at the rvalid edge
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    bit got;
    got = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (50)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        got = 1;
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        `CHK("rresp", er, s_axi_rresp)
        break;
      end
    end
    if (!got) lost();
  endtask

  function automatic bit hit(input int s);
    if (s == 0) return rx_iq_valid === 1'b1;
    if (s == 1) return ctl_out_valid === 1'b1;
    return irq_strobe[s-2] === 1'b1;
  endfunction

  // Cycles to the next pulse of a source, or lim+1 if none came
  task automatic waitp(input int s, input int lim, output int c);
    c = 0;
    do
    begin
      @(posedge aclk);
      c++;
    end
    while (c <= lim && !hit(s));
  endtask

  task automatic need(input int s, input int lim, output int c);
    waitp(s, lim, c);
    if (c > lim) lost();
  endtask

  task automatic t_regs;
    logic [31:0] d;
    rd(OFS_CTRL, RESP_OKAY, d);
    `CHK("ctrl reset", RST_CTRL, d)
    rd(OFS_SLICE, RESP_OKAY, d);
    `CHK("slice reset", RST_SLICE, d)
    rd(OFS_NCO, RESP_OKAY, d);
    `CHK("nco reset", RST_NCO, d)
    rd(OFS_IRQ_EN, RESP_OKAY, d);
    `CHK("irq enable reset", RST_IRQ_EN, d)
    rd(8'h18, RESP_DECERR, d);
    `CHK("unmapped read", 32'h0, d)
    wr(8'h18, 32'hFFFF_FFFF, RESP_DECERR);
    rd(OFS_CTRL, RESP_OKAY, d);
    `CHK("ctrl untouched", RST_CTRL, d)
  endtask

  // Tick spacing per stream count, then an illegal count
  task automatic t_rate;
    logic [3:0] dv [3] = '{DIV_1STREAM, DIV_2STREAM, DIV_4STREAM};
    logic [31:0] d;
    int c;
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_CTRL, 32'(1 << i), RESP_OKAY);
      need(0, 20, c);
      need(0, 20, c);
      `CHK("tick gap", 32'(dv[i]), c)
    end
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    repeat (4) @(posedge aclk);
    waitp(0, 40, c);
    `CHK("idle ticks", 41, c)
    `CHK("idle lanes", 128'h0, tx_lane_data)
    rd(OFS_STATUS, RESP_OKAY, d);
    `CHK("rate ok", 1'b0, d[5])
    rd(OFS_IRQ_PEND, RESP_OKAY, d);
    `CHK("rate pending", 1'b1, d[IRQ_RATE])
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
  endtask

  // Sync loss raises its own strobe; masked source stays silent
  task automatic t_irq;
    logic [31:0] d;
    int c;
    wr(OFS_IRQ_PEND, 32'h1F, RESP_OKAY);
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_IRQ_EN, k ? 32'(1 << (IRQ_EN1_LSB + IRQ_SYNC1)) : 32'(1 << IRQ_SYNC0), RESP_OKAY);
      drop[k] <= 1'b1;
      need(2 + k, 10, c);
      rd(OFS_IRQ_PEND, RESP_OKAY, d);
      `CHK("sync pending", 1'b1, d[k])
      wr(OFS_IRQ_PEND, 32'(1 << k), RESP_OKAY);
      rd(OFS_IRQ_PEND, RESP_OKAY, d);
      `CHK("sync cleared", 1'b0, d[k])
      drop[k] <= 1'b0;
    end
    wr(OFS_IRQ_EN, 32'h0, RESP_OKAY);
    repeat (4) @(posedge aclk);
    drop <= 2'h1;
    waitp(2, 10, c);
    `CHK("masked strobe", 11, c)
    drop <= 2'h0;
  endtask

  // Sync outputs, SYSREF request and the converter status inputs
  task automatic t_pins;
    logic [31:0] d;
    wr(OFS_CTRL, 32'h301, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("sync out", 2'h2, sync_out)
    `CHK("sysref request", 2'h3, sysref_req)
    drop <= 2'h1;
    sref <= 1'b1;
    @(posedge aclk);
    sref <= 1'b0;
    repeat (5) @(posedge aclk);
    rd(OFS_STATUS, RESP_OKAY, d);
    `CHK("sync status", 2'h2, d[3:2])
    rd(OFS_IRQ_PEND, RESP_OKAY, d);
    `CHK("sysref pending", 1'b1, d[IRQ_SYSREF])
    drop <= 2'h0;
  endtask

  // Bypass forwards raw lanes, thinned by the decimation setting
  task automatic t_bypass;
    int c;
    wr(OFS_CTRL, 32'h9, RESP_OKAY);
    need(0, 20, c);
    need(0, 20, c);
    `CHK("bypass data", LANE, rx_iq_data)
    wr(OFS_CTRL, 32'h409, RESP_OKAY);
    need(0, 20, c);
    need(0, 20, c);
    `CHK("bypass gap", 32'(2 * DIV_1STREAM), c)
  endtask

  // Feedback fills capture words at stream rate unless routed to receive
  task automatic t_capture;
    int c;
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    need(1, 40, c);
    need(1, 40, c);
    `CHK("capture gap", 32'(4 * DIV_1STREAM), c)
    `CHK("capture word", {4{FB}}, ctl_out_data)
    // Half-turn coefficient negates both parts of every captured sample
    ctl_in_data <= 128'h2;
    ctl_in_valid <= 1'b1;
    @(posedge aclk);
    ctl_in_valid <= 1'b0;
    need(1, 40, c);
    need(1, 40, c);
    `CHK("rotated capture", {4{32'hDB98_5320}}, ctl_out_data)
    `CHK("tx lanes", {4{32'hFFF0_FFF0}}, tx_lane_data)
    wr(OFS_CTRL, 32'h11, RESP_OKAY);
    repeat (2) @(posedge aclk);
    waitp(1, 40, c);
    `CHK("no capture", 41, c)
  endtask

  // Reset for ten cycles, then every scenario in turn
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {ctl_in_data, ctl_in_valid} = 129'h0;
    // Four carriers of -4 each: summed stream settles at -16
    tx_iq_data = {4{32'hFFFC_FFFC}};
    tx_iq_valid = 1'b1;
    drop = 2'h0;
    sref = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_rate();
    t_irq();
    t_pins();
    t_bypass();
    t_capture();
    tally_and_finish();
  end
endmodule // rfe_top_bench
